// ==== logic/orsm_datapath.sv ====
// or / shift / move execution slice with accumulator and flags
`timescale 1ns/10ps
`include "orsm_params.svh"
module orsm_datapath (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	// decoded instruction
	input wire orsm_pkg::orsm_cmd_t cmd_i,
	// register preload from the rest of the core
	input wire orsm_pkg::orsm_wr_t preload_i,
	// register file peek address for the core
	input wire logic [`ORSM_ADDR_W-1:0] peek_addr_i,
	// results
	output logic [`ORSM_DATA_W-1:0] acc_o,
	output logic result_null_bit_o,
	output logic shift_out_bit_o,
	output logic [`ORSM_DATA_W-1:0] peek_data_o
);
	orsm_pkg::orsm_state_t s_q;
	orsm_pkg::orsm_state_t s_d;
	orsm_pkg::orsm_wr_t wr;
	orsm_pkg::orsm_wr_t rf_wr;
	logic [`ORSM_DATA_W-1:0] reg_val;
	logic [`ORSM_DATA_W-1:0] res;
	logic [`ORSM_ADDR_W-1:0] rd_addr;

	// register file; combinational operand read so each op takes one cycle
	orsm_regfile u_rf (
		.ref_clk_i(ref_clk_i),
		.rst_n_i(rst_n_i),
		.rd_addr_i(peek_addr_i),
		.op_addr_i(rd_addr),
		.wr_i(rf_wr),
		.rd_data_o(peek_data_o),
		.op_data_o(reg_val)
	);

	// operand address from the instruction
	assign rd_addr = cmd_i.reg_addr;

	// instruction write wins; a preload in the same cycle is dropped
	assign rf_wr = wr.en ? wr : preload_i;

	// result and next state
	always_comb begin
		s_d = s_q;
		res = reg_val;
		wr = '0;
		unique case (cmd_i.op)
			orsm_pkg::ORSM_OP_OR: res = s_q.acc | reg_val;
			orsm_pkg::ORSM_OP_SHL: res = {reg_val[`ORSM_MSB-1:0], 1'b0};
			orsm_pkg::ORSM_OP_SHR: res = {1'b0, reg_val[`ORSM_MSB:1]};
			orsm_pkg::ORSM_OP_COPY: res = reg_val;
		endcase
		if (cmd_i.valid) begin
			s_d.flags.result_null_bit = (res == '0);
			if (cmd_i.op == orsm_pkg::ORSM_OP_SHL) begin
				s_d.flags.shift_out_bit = reg_val[`ORSM_MSB];
			end
			if (cmd_i.op == orsm_pkg::ORSM_OP_SHR) begin
				s_d.flags.shift_out_bit = reg_val[`ORSM_LSB];
			end
			if (cmd_i.target_sel == `ORSM_TGT_ACC) begin
				s_d.acc = res;
			end else begin
				wr.en = 1'b1;
				wr.addr = cmd_i.reg_addr;
				wr.data = res;
			end
		end
	end

	// state register
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign acc_o = s_q.acc;
	assign result_null_bit_o = s_q.flags.result_null_bit;
	assign shift_out_bit_o = s_q.flags.shift_out_bit;

	// named steps of one instruction, sampled at its taking edge
	sequence s_take_or;
		cmd_i.valid && cmd_i.op == orsm_pkg::ORSM_OP_OR;
	endsequence

	sequence s_take_shl;
		cmd_i.valid && cmd_i.op == orsm_pkg::ORSM_OP_SHL;
	endsequence

	sequence s_take_shr;
		cmd_i.valid && cmd_i.op == orsm_pkg::ORSM_OP_SHR;
	endsequence

	sequence s_take_copy;
		cmd_i.valid && cmd_i.op == orsm_pkg::ORSM_OP_COPY;
	endsequence

	sequence s_to_acc;
		cmd_i.valid && cmd_i.target_sel == `ORSM_TGT_ACC;
	endsequence

	sequence s_to_reg;
		cmd_i.valid && cmd_i.target_sel == `ORSM_TGT_REG;
	endsequence

	// zero flag
	a_null_flag: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		cmd_i.valid
		|=> result_null_bit_o == ($past(res) == `ORSM_ZERO))
		else $error("zero flag wrong");

	a_null_hold: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		!cmd_i.valid
		|=> $stable(result_null_bit_o))
		else $error("zero flag changed while idle");

	a_copy_zero: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		s_take_copy ##0 s_to_reg
		|=> result_null_bit_o == ($past(reg_val) == `ORSM_ZERO))
		else $error("copy to itself left zero flag wrong");

	// accumulator target
	a_acc_dest: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		s_to_acc
		|=> acc_o == $past(res))
		else $error("accumulator not written");

	a_acc_hold: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		s_to_reg
		|=> $stable(acc_o))
		else $error("accumulator changed on register target");

	a_acc_idle: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		!cmd_i.valid
		|=> $stable(acc_o))
		else $error("accumulator changed while idle");

	// result value of each op into the accumulator
	a_or_value: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		s_take_or ##0 s_to_acc
		|=> acc_o == ($past(acc_o) | $past(reg_val)))
		else $error("or result wrong");

	a_shl_value: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		s_take_shl ##0 s_to_acc
		|=> acc_o == {$past(reg_val[`ORSM_MSB-1:0]), 1'b0})
		else $error("left shift result wrong");

	a_shl_low_zero: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		s_take_shl ##0 s_to_acc
		|=> !acc_o[`ORSM_LSB])
		else $error("left shift low bit not zero");

	a_shr_value: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		s_take_shr ##0 s_to_acc
		|=> acc_o == {1'b0, $past(reg_val[`ORSM_MSB:1])})
		else $error("right shift result wrong");

	a_shr_top_zero: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		s_take_shr ##0 s_to_acc
		|=> !acc_o[`ORSM_MSB])
		else $error("right shift top bit not zero");

	a_copy_value: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		s_take_copy ##0 s_to_acc
		|=> acc_o == $past(reg_val))
		else $error("copy result wrong");

	// register target and the write port
	a_reg_write: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		s_to_reg
		|-> rf_wr.en && rf_wr.addr == cmd_i.reg_addr)
		else $error("register target not written");

	a_reg_idle: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		!cmd_i.valid
		|-> !wr.en)
		else $error("register written without instruction");

	a_or_reg_value: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		s_take_or ##0 s_to_reg
		|-> rf_wr.data == (s_q.acc | reg_val))
		else $error("or write data wrong");

	a_shl_reg_value: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		s_take_shl ##0 s_to_reg
		|-> rf_wr.data == {reg_val[`ORSM_MSB-1:0], 1'b0})
		else $error("left shift write data wrong");

	a_shr_reg_value: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		s_take_shr ##0 s_to_reg
		|-> rf_wr.data == {1'b0, reg_val[`ORSM_MSB:1]})
		else $error("right shift write data wrong");

	a_copy_self: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		s_take_copy ##0 s_to_reg
		|-> rf_wr.data == reg_val)
		else $error("copy changed register");

	a_write_seen: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		s_to_reg ##1 cmd_i.valid
		|-> cmd_i.reg_addr != $past(cmd_i.reg_addr) || reg_val == $past(res))
		else $error("next op missed the register write");

	// carry flag
	a_shl_carry: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		s_take_shl
		|=> shift_out_bit_o == $past(reg_val[`ORSM_MSB]))
		else $error("left shift carry wrong");

	a_shr_carry: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		s_take_shr
		|=> shift_out_bit_o == $past(reg_val[`ORSM_LSB]))
		else $error("right shift carry wrong");

	a_carry_hold: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		cmd_i.op inside {orsm_pkg::ORSM_OP_OR, orsm_pkg::ORSM_OP_COPY} || !cmd_i.valid
		|=> $stable(shift_out_bit_o))
		else $error("carry changed without shift");
endmodule

// ==== logic/orsm_params.svh ====
// constants of the or/shift/move datapath slice
`ifndef ORSM_PARAMS_SVH
`define ORSM_PARAMS_SVH
`define ORSM_DATA_W 8
`define ORSM_ADDR_W 7
`define ORSM_REG_CNT 128
`define ORSM_MSB 7
`define ORSM_LSB 0
`define ORSM_ZERO 8'h00
`define ORSM_ACC_RST 8'h00
`define ORSM_REG_RST 8'h00
`define ORSM_TGT_ACC 1'b0
`define ORSM_TGT_REG 1'b1
`endif

// ==== logic/orsm_pkg.sv ====
// types of the or/shift/move datapath slice
package orsm_pkg;
	typedef enum logic [1:0] {
		ORSM_OP_OR,
		ORSM_OP_SHL,
		ORSM_OP_SHR,
		ORSM_OP_COPY
	} orsm_op_t;

	// one decoded instruction from the decoder
	typedef struct packed {
		logic valid;
		orsm_op_t op;
		logic [6:0] reg_addr;
		logic target_sel;
	} orsm_cmd_t;

	// status flags driven by this slice
	typedef struct packed {
		logic result_null_bit;
		logic shift_out_bit;
	} orsm_flags_t;

	// accumulator and flags, the top module's state outside the register file
	typedef struct packed {
		logic [7:0] acc;
		orsm_flags_t flags;
	} orsm_state_t;

	// register file write port
	typedef struct packed {
		logic en;
		logic [6:0] addr;
		logic [7:0] data;
	} orsm_wr_t;
endpackage

// ==== logic/orsm_regfile.sv ====
// 128 x 8 register file, registered peek read and direct operand read
`timescale 1ns/10ps
`include "orsm_params.svh"
module orsm_regfile (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	// read and write ports
	input wire logic [`ORSM_ADDR_W-1:0] rd_addr_i,
	input wire logic [`ORSM_ADDR_W-1:0] op_addr_i,
	input wire orsm_pkg::orsm_wr_t wr_i,
	output logic [`ORSM_DATA_W-1:0] rd_data_o,
	output logic [`ORSM_DATA_W-1:0] op_data_o
);
	typedef struct packed {
		logic [`ORSM_REG_CNT-1:0][`ORSM_DATA_W-1:0] mem;
		logic [`ORSM_DATA_W-1:0] rd;
	} orsm_rf_state_t;

	orsm_rf_state_t s_q;
	orsm_rf_state_t s_d;

	// registered read then write (read sees old data on collision)
	always_comb begin
		s_d = s_q;
		s_d.rd = s_q.mem[rd_addr_i];
		if (wr_i.en) begin
			s_d.mem[wr_i.addr] = wr_i.data;
		end
	end

	// state register
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign rd_data_o = s_q.rd;
	// operand mux straight off the storage flops, same cycle
	assign op_data_o = s_q.mem[op_addr_i];
endmodule

// ==== verification/tb.sv ====
// self-checking bench of the or/shift/move datapath slice
`timescale 1ns/10ps
module tb;
	typedef struct packed {
		logic [7:0] acc;
		logic z;
		logic c;
		logic [7:0] pk;
	} orsm_exp_t;
	logic ref_clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	orsm_pkg::orsm_cmd_t cmd = '0;
	orsm_pkg::orsm_wr_t pre = '0;
	logic [6:0] peek = 7'h00;
	logic [7:0] acc_o, pk_o, acc_m, rf_m [128];
	logic z_o, c_o, z_m, c_m, v_q;
	logic [31:0] rnd = 32'h0000_97b6;
	orsm_exp_t q[$];
	int n_mismatch = 0;
	int checked = 0;
	orsm_datapath uut (
		.ref_clk_i(ref_clk_i),
		.rst_n_i(rst_n_i),
		.cmd_i(cmd),
		.preload_i(pre),
		.peek_addr_i(peek),
		.acc_o(acc_o),
		.result_null_bit_o(z_o),
		.shift_out_bit_o(c_o),
		.peek_data_o(pk_o)
	);
	// 20 MHz clock
	initial begin
		forever #25 ref_clk_i = ~ref_clk_i;
	end
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic cmp_bit(input logic got, input logic exp);
		checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] %0t flag got %b exp %b", $time, got, exp);
		end
	endtask
	// preload one register through the core's write path
	task automatic load(input logic [6:0] a, input logic [7:0] d);
		@(negedge ref_clk_i);
		rf_m[a] = d;
		cmd.valid <= 1'b0;
		pre <= {1'b1, a, d};
	endtask
	// drive one instruction and note the expected outcome
	task automatic issue(input logic [1:0] op, input logic [6:0] a, input logic t,
		input logic [6:0] p);
		logic [7:0] f, r, pk;
		@(negedge ref_clk_i);
		f = rf_m[a];
		pk = rf_m[p];
		case (op)
			2'd0: r = acc_m | f;
			2'd1: r = {f[6:0], 1'b0};
			2'd2: r = {1'b0, f[7:1]};
			default: r = f;
		endcase
		if (op == 2'd1) c_m = f[7];
		if (op == 2'd2) c_m = f[0];
		z_m = (r == 8'h00);
		if (t) rf_m[a] = r; else acc_m = r;
		q.push_back({acc_m, z_m, c_m, pk});
		cmd <= {1'b1, orsm_pkg::orsm_op_t'(op), a, t};
		peek <= p;
		pre.en <= 1'b0;
	endtask
	task automatic idle();
		@(negedge ref_clk_i);
		cmd.valid <= 1'b0;
		pre.en <= 1'b0;
	endtask
	// result watcher, one cycle after each taken instruction
	always @(posedge ref_clk_i) v_q <= cmd.valid;
	always @(negedge ref_clk_i) begin
		orsm_exp_t e;
		if (v_q === 1'b1 && q.size() > 0) begin
			e = q.pop_front();
			cmp(acc_o, e.acc);
			cmp_bit(z_o, e.z);
			cmp_bit(c_o, e.c);
			cmp(pk_o, e.pk);
		end
	end
	task automatic end_sim();
		$display("checked %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// reset, every op and target at address bounds, then random traffic
	initial begin
		acc_m = 8'h00;
		z_m = 1'b0;
		c_m = 1'b0;
		for (int i = 0; i < 128; i++) rf_m[i] = 8'h00;
		repeat (6) @(negedge ref_clk_i);
		rst_n_i = 1'b1;
		load(7'h00, 8'h81);
		load(7'h7f, 8'h40);
		for (int k = 0; k < 16; k++) begin
			issue(k[1:0], k[3] ? 7'h7f : 7'h00, k[2], k[3] ? 7'h00 : 7'h7f);
		end
		idle();
		$display("test ops and targets done");
		for (int k = 0; k < 400; k++) begin
			rnd = lfsr(rnd);
			if (rnd[17]) idle();
			if (rnd[18]) load(rnd[25:19], rnd[31:24]);
			issue(rnd[1:0], rnd[8:2], rnd[9], rnd[16:10]);
		end
		idle();
		$display("test random done");
		// mid-run reset clears accumulator, flags, peek and registers
		@(negedge ref_clk_i);
		rst_n_i = 1'b0;
		acc_m = 8'h00;
		z_m = 1'b0;
		c_m = 1'b0;
		for (int i = 0; i < 128; i++) rf_m[i] = 8'h00;
		repeat (2) @(negedge ref_clk_i);
		cmp(acc_o, 8'h00);
		cmp_bit(z_o, 1'b0);
		cmp_bit(c_o, 1'b0);
		cmp(pk_o, 8'h00);
		rst_n_i = 1'b1;
		load(7'h11, 8'h01);
		issue(2'd2, 7'h11, 1'b0, 7'h11);
		issue(2'd3, 7'h11, 1'b1, 7'h11);
		idle();
		repeat (3) @(negedge ref_clk_i);
		if (q.size() != 0) n_mismatch++;
		$display("test mid reset done");
		end_sim();
	end
endmodule
